/* File: shared/pirpc_pkg.sv */
// ============================================================
// event, reset and power-down constants
package pirpc_pkg;
  // clock and times
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned ENERGY_TIMEOUT_MS = 256;
  localparam int unsigned SOFT_RESET_US = 256;
  localparam int unsigned PD_RESET_US = 256;
  localparam int unsigned ENERGY_TIMEOUT_CYC = (CLK_HZ / 1000) * ENERGY_TIMEOUT_MS;
  localparam int unsigned SOFT_RESET_CYC = (CLK_HZ / 1_000_000) * SOFT_RESET_US;
  localparam int unsigned PD_RESET_CYC = (CLK_HZ / 1_000_000) * PD_RESET_US;
  localparam int unsigned TIMER_W = 24;
  localparam int unsigned CFG_SETTLE_CYC = 3;

  // register indices
  localparam logic [4:0] REG_BASIC_CTRL = 5'h00;
  localparam logic [4:0] REG_BASIC_STAT = 5'h01;
  localparam logic [4:0] REG_AN_EXPANSION = 5'h06;
  localparam logic [4:0] REG_IDLE_ERR_CNT = 5'h0a;
  localparam logic [4:0] REG_MODE_CTRL = 5'h11;
  localparam logic [4:0] REG_INT_SOURCE = 5'h1d;
  localparam logic [4:0] REG_INT_MASK = 5'h1e;

  // field positions
  localparam int unsigned CTRL_SOFT_RESET_BIT = 15;
  localparam int unsigned CTRL_POWER_DOWN_BIT = 11;
  localparam int unsigned MODE_EDPD_BIT = 13;
  localparam int unsigned MODE_ENERGY_BIT = 1;
  localparam int unsigned FLG_TX_OVF = 10;
  localparam int unsigned FLG_TX_UNF = 9;
  localparam int unsigned FLG_IDLE_OVF = 8;
  localparam int unsigned FLG_ENERGY = 7;
  localparam int unsigned FLG_AN_DONE = 6;
  localparam int unsigned FLG_REM_FAULT = 5;
  localparam int unsigned FLG_LINK_DOWN = 4;
  localparam int unsigned FLG_PAR_FAULT = 2;
  localparam int unsigned FLG_PAGE_RX = 1;

  // implemented flag positions, reset values
  localparam logic [15:0] FLAG_IMPL = 16'h07f6;
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic ENERGY_RST = 1'b1;
  localparam logic EDPD_RST = 1'b0;
endpackage

/* File: rtl/pirpc_sync.sv */
`timescale 1ns/10ps
// ============================================================
// two-stage synchroniser, one per bit
module pirpc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta_r;
      logic sync_r;
      // first stage feeds only the second
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end
        else
        begin
          meta_r <= d[i];
          sync_r <= meta_r;
        end
      end
      assign q[i] = sync_r;
    end
  endgenerate
endmodule // pirpc_sync

/* File: rtl/pirpc_timer.sv */
`timescale 1ns/10ps
// ============================================================
// down-counter, one-cycle done pulse at expiry
module pirpc_timer #(
  parameter int W = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic stop,
  input wire logic [W-1:0] load,
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt_r, cnt_nxt;
  logic done_r, done_nxt;

  // next count; start reloads, stop abandons
  always_comb
  begin
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (start)
      cnt_nxt = load;
    else if (stop)
      cnt_nxt = '0;
    else if (cnt_r != '0)
    begin
      cnt_nxt = cnt_r - 1'b1;
      done_nxt = (cnt_r == {{(W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy = (cnt_r != '0);
  assign done = done_r;
endmodule // pirpc_timer

/* File: rtl/pirpc_top.sv */
`timescale 1ns/10ps
// ============================================================
// event flags, interrupt, resets and power-down
module pirpc_top
  import pirpc_pkg::*;
#(
  parameter int unsigned ENERGY_CYC = ENERGY_TIMEOUT_CYC,
  parameter int unsigned SRST_CYC = SOFT_RESET_CYC,
  parameter int unsigned PDRST_CYC = PD_RESET_CYC
) (
  // clock and hardware reset
  input wire logic clk,
  input wire logic rst,
  // register access from the management port
  input wire logic mgmt_wr_en,
  input wire logic mgmt_rd_en,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  // status from the core, same clock
  input wire logic an_complete,
  input wire logic remote_fault,
  input wire logic link_status,
  input wire logic par_det_fault,
  input wire logic page_received,
  input wire logic tx_fifo_ovf,
  input wire logic tx_fifo_unf,
  input wire logic idle_err_ovf,
  input wire logic renegotiate,
  input wire logic manual_mode,
  input wire logic ability_detect,
  // line energy from the line_detector_a detector, asynchronous
  input wire logic line_detector_a,
  // configuration pins and straps, asynchronous
  input wire logic [3:0] config_pins,
  input wire logic [1:0] config_straps,
  // outputs
  output logic irq_n,
  output logic core_reset,
  output logic core_power_down,
  output logic tx_inhibit,
  output logic [3:0] cfg_pins_latched,
  output logic [1:0] cfg_straps_latched,
  output logic cfg_valid
);
  import pirpc_pkg::*;

  typedef enum {RS_RUN, RS_SOFT, RS_PD} pirpc_rst_t;
  typedef enum {EN_BOOT, EN_ON, EN_WAIT_AD, EN_LOST, EN_HOLD, EN_OFF} pirpc_en_t;

  // ============================================================
  // input synchronisers
  logic energy_s;
  logic [3:0] cfg_pins_s;
  logic [1:0] cfg_straps_s;

  pirpc_sync #(.W(7)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({line_detector_a, config_pins, config_straps}),
    .q({energy_s, cfg_pins_s, cfg_straps_s})
  );

  // ============================================================
  // strap and config pin capture after hardware reset release
  logic [1:0] cfg_wait_r, cfg_wait_nxt;
  logic cfg_valid_r, cfg_valid_nxt;
  logic [3:0] cfg_pins_r, cfg_pins_nxt;
  logic [1:0] cfg_straps_r, cfg_straps_nxt;

  // waits out synchroniser depth, captures once
  always_comb
  begin
    cfg_wait_nxt = cfg_wait_r;
    cfg_valid_nxt = cfg_valid_r;
    cfg_pins_nxt = cfg_pins_r;
    cfg_straps_nxt = cfg_straps_r;
    if (!cfg_valid_r)
    begin
      if (cfg_wait_r != 2'h0)
        cfg_wait_nxt = cfg_wait_r - 2'h1;
      else
      begin
        cfg_valid_nxt = 1'b1;
        cfg_pins_nxt = cfg_pins_s;
        cfg_straps_nxt = cfg_straps_s;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_wait_r <= 2'(CFG_SETTLE_CYC - 1);
      cfg_valid_r <= 1'b0;
      cfg_pins_r <= 4'h0;
      cfg_straps_r <= 2'h0;
    end
    else
    begin
      cfg_wait_r <= cfg_wait_nxt;
      cfg_valid_r <= cfg_valid_nxt;
      cfg_pins_r <= cfg_pins_nxt;
      cfg_straps_r <= cfg_straps_nxt;
    end
  end

  // ============================================================
  // soft reset and power-down reset sequencing
  pirpc_rst_t rs_r, rs_nxt;
  logic soft_bit_r, soft_bit_nxt;
  logic pd_bit_r, pd_bit_nxt;
  logic edpd_r, edpd_nxt;
  logic rst_tmr_start, rst_tmr_done;
  logic [TIMER_W-1:0] rst_tmr_load;
  logic ctrl_wr, logic_clr;

  assign ctrl_wr = mgmt_wr_en && (mgmt_addr == REG_BASIC_CTRL);
  assign logic_clr = (rs_r == RS_SOFT);

  // state, self-clearing soft bit, power-down bit
  always_comb
  begin
    rs_nxt = rs_r;
    soft_bit_nxt = soft_bit_r;
    pd_bit_nxt = pd_bit_r;
    edpd_nxt = edpd_r; // exempt from soft reset
    rst_tmr_start = 1'b0;
    rst_tmr_load = TIMER_W'(SRST_CYC);
    if (mgmt_wr_en && (mgmt_addr == REG_MODE_CTRL))
      edpd_nxt = mgmt_wdata[MODE_EDPD_BIT];
    case (rs_r)
      RS_RUN:
      begin
        if (ctrl_wr && mgmt_wdata[CTRL_SOFT_RESET_BIT])
        begin
          rs_nxt = RS_SOFT;
          soft_bit_nxt = 1'b1;
          rst_tmr_start = 1'b1;
        end
        else if (ctrl_wr)
        begin
          pd_bit_nxt = mgmt_wdata[CTRL_POWER_DOWN_BIT];
          if (pd_bit_r && !mgmt_wdata[CTRL_POWER_DOWN_BIT])
          begin
            rs_nxt = RS_PD;
            rst_tmr_start = 1'b1;
            rst_tmr_load = TIMER_W'(PDRST_CYC);
          end
        end
      end
      RS_SOFT:
      begin
        pd_bit_nxt = 1'b0;
        if (rst_tmr_done)
        begin
          rs_nxt = RS_RUN;
          soft_bit_nxt = 1'b0;
        end
      end
      RS_PD:
      begin
        if (rst_tmr_done)
          rs_nxt = RS_RUN;
      end
      default:
        rs_nxt = RS_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rs_r <= RS_RUN;
      soft_bit_r <= 1'b0;
      pd_bit_r <= 1'b0;
      edpd_r <= EDPD_RST;
    end
    else
    begin
      rs_r <= rs_nxt;
      soft_bit_r <= soft_bit_nxt;
      pd_bit_r <= pd_bit_nxt;
      edpd_r <= edpd_nxt;
    end
  end

  pirpc_timer #(.W(TIMER_W)) u_rst_tmr (
    .clk(clk),
    .rst(rst),
    .start(rst_tmr_start),
    .stop(1'b0),
    .load(rst_tmr_load),
    .busy(),
    .done(rst_tmr_done)
  );

  // ============================================================
  // energy present tracking
  pirpc_en_t en_r, en_nxt;
  logic present_r, present_nxt;
  logic boot_r;
  logic en_tmr_start, en_tmr_done, energy_evt;

  // boot timeout, arrival, loss delay, clear delay
  always_comb
  begin
    en_nxt = en_r;
    present_nxt = present_r;
    en_tmr_start = 1'b0;
    energy_evt = 1'b0;
    case (en_r)
      EN_BOOT:
      begin
        en_tmr_start = boot_r;
        if (energy_s)
          en_nxt = EN_ON;
        else if (en_tmr_done)
        begin
          en_nxt = EN_OFF;
          present_nxt = 1'b0;
        end
      end
      EN_OFF:
      begin
        if (energy_s)
        begin
          en_nxt = EN_ON;
          present_nxt = 1'b1;
          energy_evt = 1'b1;
        end
      end
      EN_ON:
      begin
        if (!energy_s && manual_mode)
        begin
          en_nxt = EN_LOST;
          en_tmr_start = 1'b1;
        end
        else if (!energy_s)
          en_nxt = EN_WAIT_AD;
      end
      EN_WAIT_AD:
      begin
        if (energy_s)
          en_nxt = EN_ON;
        else if (ability_detect)
        begin
          en_nxt = EN_LOST;
          en_tmr_start = 1'b1;
        end
      end
      EN_LOST:
      begin
        if (energy_s)
          en_nxt = EN_ON;
        else if (en_tmr_done)
        begin
          en_nxt = EN_HOLD;
          energy_evt = 1'b1;
          en_tmr_start = 1'b1;
        end
      end
      EN_HOLD:
      begin
        if (en_tmr_done)
        begin
          en_nxt = EN_OFF;
          present_nxt = 1'b0;
        end
      end
      default:
        en_nxt = EN_OFF;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      en_r <= EN_BOOT;
      present_r <= ENERGY_RST;
      boot_r <= 1'b1;
    end
    else
    begin
      en_r <= en_nxt;
      present_r <= present_nxt;
      boot_r <= 1'b0;
    end
  end

  pirpc_timer #(.W(TIMER_W)) u_en_tmr (
    .clk(clk),
    .rst(rst),
    .start(en_tmr_start),
    .stop(1'b0),
    .load(TIMER_W'(ENERGY_CYC)),
    .busy(),
    .done(en_tmr_done)
  );

  // ============================================================
  // source flags, mask and read data
  logic [15:0] flags_r, flags_nxt, mask_r, mask_nxt, rdata_r, rdata_nxt;
  logic [15:0] set_v, clr_v;
  logic [5:0] prev_r;
  logic present_d_r;
  logic irq_n_r, irq_n_nxt;
  logic rd_stat, rd_exp, rd_idle, rd_src, link_fall;

  assign rd_stat = mgmt_rd_en && (mgmt_addr == REG_BASIC_STAT);
  assign rd_exp = mgmt_rd_en && (mgmt_addr == REG_AN_EXPANSION);
  assign rd_idle = mgmt_rd_en && (mgmt_addr == REG_IDLE_ERR_CNT);
  assign rd_src = mgmt_rd_en && (mgmt_addr == REG_INT_SOURCE);
  assign link_fall = prev_r[2] && !link_status;

  // set and clear terms; set wins over clear
  always_comb
  begin
    set_v = 16'h0000;
    clr_v = 16'h0000;
    set_v[FLG_TX_OVF] = tx_fifo_ovf;
    clr_v[FLG_TX_OVF] = !tx_fifo_ovf;
    set_v[FLG_TX_UNF] = tx_fifo_unf;
    clr_v[FLG_TX_UNF] = !tx_fifo_unf;
    set_v[FLG_IDLE_OVF] = idle_err_ovf && !prev_r[0];
    clr_v[FLG_IDLE_OVF] = rd_idle;
    set_v[FLG_ENERGY] = energy_evt;
    clr_v[FLG_ENERGY] = (present_d_r && !present_r) || rd_src;
    set_v[FLG_AN_DONE] = an_complete && !prev_r[1];
    clr_v[FLG_AN_DONE] = (prev_r[1] && !an_complete) || rd_src;
    set_v[FLG_REM_FAULT] = remote_fault && !prev_r[3];
    clr_v[FLG_REM_FAULT] = (prev_r[3] && !remote_fault) || rd_stat || rd_src;
    set_v[FLG_LINK_DOWN] = link_fall;
    clr_v[FLG_LINK_DOWN] = rd_stat || rd_src;
    set_v[FLG_PAR_FAULT] = par_det_fault && !prev_r[4];
    clr_v[FLG_PAR_FAULT] = (prev_r[4] && !par_det_fault) || rd_exp || rd_src
      || renegotiate || link_fall;
    set_v[FLG_PAGE_RX] = page_received && !prev_r[5];
    clr_v[FLG_PAGE_RX] = (prev_r[5] && !page_received) || rd_exp || rd_src
      || renegotiate || link_fall;
    flags_nxt = ((flags_r & ~clr_v) | set_v) & FLAG_IMPL;
    mask_nxt = mask_r;
    if (mgmt_wr_en && (mgmt_addr == REG_INT_MASK))
      mask_nxt = mgmt_wdata & FLAG_IMPL;
    if (logic_clr)
    begin
      flags_nxt = FLAGS_RST;
      mask_nxt = MASK_RST;
    end
    irq_n_nxt = ~|(flags_r & mask_r & FLAG_IMPL);
    rdata_nxt = 16'h0000;
    case (mgmt_addr)
      REG_BASIC_CTRL:
      begin
        rdata_nxt[CTRL_SOFT_RESET_BIT] = soft_bit_r;
        rdata_nxt[CTRL_POWER_DOWN_BIT] = pd_bit_r;
      end
      REG_MODE_CTRL:
      begin
        rdata_nxt[MODE_EDPD_BIT] = edpd_r;
        rdata_nxt[MODE_ENERGY_BIT] = present_r;
      end
      REG_INT_SOURCE:
        rdata_nxt = flags_r;
      REG_INT_MASK:
        rdata_nxt = mask_r;
      default:
        rdata_nxt = 16'h0000;
    endcase
    if (!mgmt_rd_en)
      rdata_nxt = rdata_r;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flags_r <= FLAGS_RST;
      mask_r <= MASK_RST;
      prev_r <= 6'h00;
      present_d_r <= ENERGY_RST;
      irq_n_r <= 1'b1;
      rdata_r <= 16'h0000;
    end
    else
    begin
      flags_r <= flags_nxt;
      mask_r <= mask_nxt;
      prev_r <= {page_received, par_det_fault, remote_fault, link_status, an_complete,
        idle_err_ovf};
      present_d_r <= present_r;
      irq_n_r <= irq_n_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ============================================================
  // power and reset outputs
  logic core_reset_r, core_pd_r, tx_inh_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      core_reset_r <= 1'b1;
      core_pd_r <= 1'b0;
      tx_inh_r <= 1'b0;
    end
    else
    begin
      core_reset_r <= (rs_nxt != RS_RUN);
      core_pd_r <= pd_bit_nxt || (edpd_r && !energy_s);
      tx_inh_r <= edpd_r && !energy_s;
    end
  end

  assign irq_n = irq_n_r;
  assign core_reset = core_reset_r;
  assign core_power_down = core_pd_r;
  assign tx_inhibit = tx_inh_r;
  assign mgmt_rdata = rdata_r;
  assign cfg_pins_latched = cfg_pins_r;
  assign cfg_straps_latched = cfg_straps_r;
  assign cfg_valid = cfg_valid_r;
endmodule // pirpc_top

/* File: sim/pirpc_properties.sv */
`timescale 1ns/10ps
// ============================================================
// port-level checks on the event, reset and power-down block
module pirpc_properties
  import pirpc_pkg::*;
#(
  parameter int unsigned SRST_CYC = 20,
  parameter int unsigned PDRST_CYC = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic mgmt_wr_en,
  input wire logic mgmt_rd_en,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  // outputs
  input wire logic irq_n,
  input wire logic core_reset,
  input wire logic core_power_down,
  input wire logic tx_inhibit,
  input wire logic [3:0] cfg_pins_latched,
  input wire logic [1:0] cfg_straps_latched,
  input wire logic cfg_valid
);
  import pirpc_pkg::*;
  logic [15:0] hold_r;
  logic [15:0] hold_nxt;
  logic wr_ctrl;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // cycles spent with core_reset high
  always_comb
  begin
    hold_nxt = core_reset ? hold_r + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hold_r <= 16'h0000;
    else
      hold_r <= hold_nxt;
  end
  // control register write that the block accepts
  assign wr_ctrl = mgmt_wr_en && mgmt_addr == REG_BASIC_CTRL && !core_reset;
  // ============================================================
  // assertions
  a_irq_after_reset: assert property ($fell(rst) |-> irq_n)
    else $error("irq_n low right after reset");
  a_soft_rst_start: assert property (wr_ctrl && mgmt_wdata[CTRL_SOFT_RESET_BIT] |=> core_reset)
    else $error("soft reset did not start");
  a_reset_len_ok: assert property ($fell(core_reset) |->
    (hold_r == SRST_CYC + 1 || hold_r == PDRST_CYC + 1 || hold_r == 16'h0001))
    else $error("core reset held for a wrong count");
  a_pd_enter: assert property (wr_ctrl && mgmt_wdata[CTRL_POWER_DOWN_BIT]
    && !mgmt_wdata[CTRL_SOFT_RESET_BIT] |=> core_power_down)
    else $error("power-down bit did not power down");
  a_pd_exit_rst: assert property (wr_ctrl && mgmt_wdata == 16'h0000 && core_power_down
    && !tx_inhibit |=> core_reset [*2])
    else $error("no reset on leaving power-down");
  a_edpd_quiet: assert property (tx_inhibit |-> core_power_down)
    else $error("transmit inhibited while core powered");
  a_rsvd_zero: assert property (mgmt_rd_en && (mgmt_addr == REG_INT_SOURCE
    || mgmt_addr == REG_INT_MASK) |=> (mgmt_rdata & ~FLAG_IMPL) == 16'h0000)
    else $error("reserved flag or mask bit reads one");
  a_mask_off_irq: assert property (mgmt_wr_en && mgmt_addr == REG_INT_MASK
    && (mgmt_wdata & FLAG_IMPL) == 16'h0000 |-> ##2 irq_n)
    else $error("irq_n low with all enables clear");
  a_cfg_capture: assert property ($fell(rst) |-> ##[1:4] cfg_valid)
    else $error("configuration not captured after reset");
  a_cfg_held: assert property (cfg_valid |=> cfg_valid && $stable(cfg_pins_latched)
    && $stable(cfg_straps_latched))
    else $error("captured configuration changed");
  // main scenarios
  c_soft_rst: cover property (wr_ctrl && mgmt_wdata[CTRL_SOFT_RESET_BIT]);
  c_pd_wake: cover property ($fell(core_power_down));
  c_irq_low: cover property ($fell(irq_n));
endmodule // pirpc_properties

bind pirpc_top pirpc_properties #(.SRST_CYC(SRST_CYC), .PDRST_CYC(PDRST_CYC)) i_props (
  .clk(clk), .rst(rst), .mgmt_wr_en(mgmt_wr_en), .mgmt_rd_en(mgmt_rd_en),
  .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
  .irq_n(irq_n), .core_reset(core_reset), .core_power_down(core_power_down),
  .tx_inhibit(tx_inhibit), .cfg_pins_latched(cfg_pins_latched),
  .cfg_straps_latched(cfg_straps_latched), .cfg_valid(cfg_valid)
);

/* File: sim/pirpc_smc_model.sv */
`timescale 1ns/10ps
// ============================================================
// station manager: register cycles and interrupt service
module pirpc_smc_model
  import pirpc_pkg::*;
(
  // clock
  input wire logic clk,
  // register port toward the block
  output logic mgmt_wr_en,
  output logic mgmt_rd_en,
  output logic [4:0] mgmt_addr,
  output logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  input wire logic irq_n
);
  import pirpc_pkg::*;
  // idle port, address and data parked on junk
  initial
  begin
    mgmt_wr_en = 1'b0;
    mgmt_rd_en = 1'b0;
    mgmt_addr = 5'h1f;
    mgmt_wdata = 16'ha5a5;
  end
  // one write, strobe for a single cycle
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    mgmt_wr_en <= 1'b1;
    mgmt_addr <= a;
    mgmt_wdata <= d;
    @(posedge clk);
    mgmt_wr_en <= 1'b0;
    mgmt_addr <= ~a;
    mgmt_wdata <= ~d;
  endtask
  // one read, data taken the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    mgmt_rd_en <= 1'b1;
    mgmt_addr <= a;
    @(posedge clk);
    mgmt_rd_en <= 1'b0;
    mgmt_addr <= ~a;
    #1 d = mgmt_rdata;
  endtask
  // energy handler: fetch flags, then drop the energy enable
  task automatic service(output logic [15:0] flags);
    logic [15:0] m;
    rd(REG_INT_SOURCE, flags);
    rd(REG_INT_MASK, m);
    wr(REG_INT_MASK, m & ~(16'h0001 << FLG_ENERGY));
  endtask
endmodule // pirpc_smc_model

/* File: sim/tb_phy_irq_reset_powerdown_ctrl.sv */
`timescale 1ns/10ps
// ============================================================
// bench for the event, reset and power-down block
module tb_phy_irq_reset_powerdown_ctrl;
  import pirpc_pkg::*;
  localparam int unsigned SIM_CYC = 20;
  logic clk, rst, mgmt_wr_en, mgmt_rd_en, irq_n, core_reset, core_power_down;
  logic tx_inhibit, cfg_valid, renegotiate, manual_mode, ability_detect, line_energy;
  logic [4:0] mgmt_addr;
  logic [15:0] mgmt_wdata, mgmt_rdata;
  logic [7:0] src;
  logic [3:0] cfg_pins, cfg_pins_latched;
  logic [1:0] cfg_straps, cfg_straps_latched;
  int err_total = 0;
  int n_compared = 0;
  int cyc_cnt = 0;
  int unsigned fbit [8] = '{FLG_AN_DONE, FLG_REM_FAULT, FLG_LINK_DOWN, FLG_PAR_FAULT,
    FLG_PAGE_RX, FLG_TX_OVF, FLG_TX_UNF, FLG_IDLE_OVF};
  // ============================================================
  // clock, design and station manager
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  pirpc_top #(.ENERGY_CYC(SIM_CYC), .SRST_CYC(SIM_CYC), .PDRST_CYC(SIM_CYC)) i_dut (
    .clk(clk), .rst(rst), .mgmt_wr_en(mgmt_wr_en), .mgmt_rd_en(mgmt_rd_en),
    .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .an_complete(src[0]), .remote_fault(src[1]), .link_status(src[2]),
    .par_det_fault(src[3]), .page_received(src[4]), .tx_fifo_ovf(src[5]),
    .tx_fifo_unf(src[6]), .idle_err_ovf(src[7]), .renegotiate(renegotiate),
    .manual_mode(manual_mode), .ability_detect(ability_detect),
    .line_detector_a(line_energy), .config_pins(cfg_pins), .config_straps(cfg_straps),
    .irq_n(irq_n), .core_reset(core_reset), .core_power_down(core_power_down),
    .tx_inhibit(tx_inhibit), .cfg_pins_latched(cfg_pins_latched),
    .cfg_straps_latched(cfg_straps_latched), .cfg_valid(cfg_valid));
  pirpc_smc_model i_smc (.clk(clk), .mgmt_wr_en(mgmt_wr_en), .mgmt_rd_en(mgmt_rd_en),
    .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .irq_n(irq_n));
  // ============================================================
  // shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // bounded wait for the interrupt line to go low
  task automatic wait_irq(input int lim);
    int n = 0;
    while (irq_n !== 1'b0 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    #1 check(irq_n, 16'h0000);
  endtask
  // hardware reset with new pins, then captured values
  task automatic t_hw(input logic [3:0] pins);
    logic [15:0] d;
    @(posedge clk) cfg_pins <= pins;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    check(cfg_pins_latched, 16'(pins));
    check(cfg_valid, 16'h0001);
    check(cfg_straps_latched, 16'(cfg_straps));
    i_smc.rd(REG_INT_MASK, d);
    check(d, 16'h0000);
    i_smc.rd(REG_MODE_CTRL, d);
    check(d, 16'h0002);
  endtask
  // every core flag source toggled and restored (link_status lowered, the rest raised), flags read back
  task automatic t_flags();
    logic [15:0] d;
    i_smc.wr(REG_INT_MASK, 16'hffff);
    i_smc.rd(REG_INT_MASK, d);
    check(d, FLAG_IMPL);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk) src[i] <= ~src[i];
      repeat (4) @(posedge clk);
      #1 check(irq_n, 16'h0000);
      i_smc.rd(REG_INT_SOURCE, d);
      check(d, 16'(16'h0001 << fbit[i]));
      @(posedge clk) src[i] <= ~src[i];
      repeat (4) @(posedge clk);
      i_smc.rd(REG_INT_SOURCE, d);
      check(d, (i == 7) ? 16'h0100 : 16'h0000);
    end
    i_smc.rd(REG_IDLE_ERR_CNT, d);
    i_smc.rd(REG_INT_SOURCE, d);
    check(d, 16'h0000);
    repeat (2) @(posedge clk);
    #1 check(irq_n, 16'h0001);
  endtask
  // status read and renegotiation clear latched flags
  task automatic t_clears();
    logic [15:0] d;
    @(posedge clk) src[2] <= 1'b0;
    repeat (3) @(posedge clk);
    i_smc.rd(REG_BASIC_STAT, d);
    i_smc.rd(REG_INT_SOURCE, d);
    check(d, 16'h0000);
    @(posedge clk) src[2] <= 1'b1;
    src[4] <= 1'b1;
    repeat (3) @(posedge clk);
    renegotiate <= 1'b1;
    @(posedge clk) renegotiate <= 1'b0;
    i_smc.rd(REG_INT_SOURCE, d);
    check(d, 16'h0000);
    @(posedge clk) src[4] <= 1'b0;
  endtask
  // energy loss in manual mode, then wake from energy-detect power-down
  task automatic t_energy();
    logic [15:0] d;
    i_smc.wr(REG_INT_MASK, 16'h0080);
    @(posedge clk) line_energy <= 1'b0;
    repeat (12) @(posedge clk);
    #1 check(irq_n, 16'h0001);
    wait_irq(40);
    i_smc.service(d);
    check(d, 16'h0080);
    repeat (SIM_CYC + 10) @(posedge clk);
    i_smc.rd(REG_MODE_CTRL, d);
    check(d, 16'h0000);
    i_smc.wr(REG_MODE_CTRL, 16'h2000);
    repeat (4) @(posedge clk);
    #1 check(tx_inhibit, 16'h0001);
    check(core_power_down, 16'h0001);
    i_smc.wr(REG_INT_MASK, 16'h0080);
    @(posedge clk) line_energy <= 1'b1;
    wait_irq(12);
    check(tx_inhibit, 16'h0000);
    i_smc.rd(REG_MODE_CTRL, d);
    check(d, 16'h2002);
    i_smc.rd(REG_INT_SOURCE, d);
    check(d, 16'h0080);
    // autonegotiating: loss flagged only after ability detect
    @(posedge clk) manual_mode <= 1'b0;
    line_energy <= 1'b0;
    repeat (SIM_CYC + 10) @(posedge clk);
    #1 check(irq_n, 16'h0001);
    @(posedge clk) ability_detect <= 1'b1;
    wait_irq(SIM_CYC + 6);
    @(posedge clk) ability_detect <= 1'b0;
    manual_mode <= 1'b1;
    line_energy <= 1'b1;
    repeat (SIM_CYC + 8) @(posedge clk);
    i_smc.rd(REG_INT_SOURCE, d);
    check(d, 16'h0080);
  endtask
  // soft reset keeps exempt bits and captured pins
  task automatic t_soft();
    logic [15:0] d;
    @(posedge clk) cfg_pins <= 4'h5;
    cfg_straps <= 2'b01;
    i_smc.wr(REG_BASIC_CTRL, 16'h8000);
    i_smc.rd(REG_BASIC_CTRL, d);
    check(d, 16'h8000);
    repeat (SIM_CYC + 4) @(posedge clk);
    i_smc.rd(REG_BASIC_CTRL, d);
    check(d, 16'h0000);
    i_smc.rd(REG_INT_MASK, d);
    check(d, 16'h0000);
    i_smc.rd(REG_MODE_CTRL, d);
    check(d & 16'h2000, 16'h2000);
    check(cfg_pins_latched, 16'h000a);
    check(cfg_straps_latched, 16'h0002);
    i_smc.wr(REG_MODE_CTRL, 16'h0000);
  endtask
  // general power-down and the reset on leaving it
  task automatic t_pd();
    logic [15:0] d;
    i_smc.wr(REG_INT_MASK, 16'h0040);
    i_smc.wr(REG_BASIC_CTRL, 16'h0800);
    repeat (2) @(posedge clk);
    #1 check(core_power_down, 16'h0001);
    i_smc.wr(REG_BASIC_CTRL, 16'h0000);
    repeat (2) @(posedge clk);
    #1 check(core_reset, 16'h0001);
    i_smc.rd(REG_INT_MASK, d);
    check(d, 16'h0040);
    repeat (SIM_CYC + 4) @(posedge clk);
    #1 check(core_reset, 16'h0000);
    check(core_power_down, 16'h0000);
  endtask
  // ============================================================
  // run and hang guard
  initial
  begin
    rst = 1'b1;
    src = 8'h04;
    renegotiate = 1'b0;
    manual_mode = 1'b1;
    ability_detect = 1'b0;
    line_energy = 1'b1;
    cfg_pins = 4'ha;
    cfg_straps = 2'b10;
    t_hw(4'ha);
    t_flags();
    t_clears();
    t_energy();
    t_soft();
    t_pd();
    t_hw(4'h3);
    close_out();
  end
  always @(posedge clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 3000)
    begin
      err_total++;
      close_out();
    end
  end
endmodule // tb_phy_irq_reset_powerdown_ctrl
